/* nvm_self_access_pkg.sv */
// package for the self-access nonvolatile memory controller
// assumes the core reaches registers through a small select code and read and write strobes
package nvm_self_access_pkg;

  // ************************************************************
  // register select codes
  // ************************************************************
  localparam logic [2:0] sel_control   = 3'h0;
  localparam logic [2:0] sel_unlock    = 3'h1;
  localparam logic [2:0] sel_data_low  = 3'h2;
  localparam logic [2:0] sel_data_high = 3'h3;
  localparam logic [2:0] sel_addr_low  = 3'h4;
  localparam logic [2:0] sel_addr_high = 3'h5;
  localparam logic [2:0] sel_flags_two = 3'h6;

  // ************************************************************
  // control fields and flag positions
  // ************************************************************
  localparam int bit_fetch_go     = 0;
  localparam int bit_store_go     = 1;
  localparam int bit_store_permit = 2;
  localparam int bit_aborted      = 3;
  localparam int bit_space_select = 7;
  localparam int bit_store_done   = 4;

  // ************************************************************
  // sizes, unlock pattern and timing
  // ************************************************************
  localparam int          data_addr_bits = 7;
  localparam int          prog_addr_bits = 12;
  localparam int          prog_word_bits = 14;
  localparam logic [7:0]  unlock_first   = 8'h55;
  localparam logic [7:0]  unlock_second  = 8'hAA;
  localparam int          store_time_us  = 4;
  localparam int          clk_mhz        = 250;
  localparam int          store_cycles   = store_time_us * clk_mhz;
  localparam int          fetch_cycles   = 2;
  localparam logic [7:0]  reset_zero     = 8'h00;

  typedef enum logic [1:0] {idle_st, fetch_st, store_st} phase_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    phase_type   phase;
    logic [9:0]  timer;
    logic [1:0]  unlock_step;
    logic        space_select;
    logic        store_permit;
    logic        aborted;
    logic        store_done;
    logic        fetch_go;
    logic        store_go;
    logic [7:0]  addr_low;
    logic [7:0]  addr_high;
    logic [7:0]  data_low;
    logic [7:0]  data_high;
    logic [7:0]  rdata;
    logic        stall;
    logic        pump_on;
  } state_type;

endpackage : nvm_self_access_pkg

/* nvm_self_access.sv */
// self-access controller for data eeprom and program flash
// assumes the core issues one register access per cycle and honours stall
// What this block does
// - data eeprom uses addr_low and data_low bytes
// - data reads at 80h-FFh wrap to start
// - pump off on unimplemented data write
// - program word is 14 bits, address 12
// - program addresses wrap beyond top address
// - byte data access, word read, block write
// - program write erases aligned four-word block
// - data byte write erases then programs
// - internal timer sets write length
// - protection still allows internal access, program writes gated
// - protection blocks external programmer access
// - addr_high bits 7:5 not implemented, bit 4 kept but unused
// - space_select picks program or data, resets clear
// - go bits set-only, hardware clears at completion
// - store_permit gates writes, clear at power-up
// - warm reset mid-write flags abort, keeps address and data regs
// - store_done_flag sticky until software clears
// - nvm_unlock has no storage, reads zero
// - program read stalls two cycles then data
// - data pair holds last read value
`timescale 1ns/1ps
module nvm_self_access (
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  input  wire logic                             por,
  input  wire logic                             warm_reset,
  input  wire nvm_self_access_pkg::reg_req_type req,
  input  wire logic                             block_protect,
  input  wire logic                             code_protect,
  input  wire logic                             prog_req,
  output logic [7:0]                            rdata,
  output logic                                  stall,
  output logic                                  pump_on,
  output logic                                  prog_access_ok
);

  // ************************************************************
  // storage arrays
  // ************************************************************
  logic [7:0]  data_mem [0:(1 << nvm_self_access_pkg::data_addr_bits) - 1];
  logic [13:0] prog_mem [0:(1 << nvm_self_access_pkg::prog_addr_bits) - 1];

  nvm_self_access_pkg::state_type cur;
  nvm_self_access_pkg::state_type next_st;

  logic [6:0]  data_index;
  logic [11:0] prog_index;
  logic        data_unimpl;
  logic        store_end;
  logic        prot_ok;
  logic        wr_space;
  logic        wr_permit;

  assign data_index  = cur.addr_low[6:0];
  assign data_unimpl = cur.addr_low[7];
  assign prog_index  = {cur.addr_high[3:0], cur.addr_low};
  // the space and permit bits carried by the starting write steer that operation
  assign wr_space    = req.wdata[nvm_self_access_pkg::bit_space_select];
  assign wr_permit   = req.wdata[nvm_self_access_pkg::bit_store_permit];
  assign prot_ok     = !wr_space || !block_protect;
  assign store_end   = (cur.phase == nvm_self_access_pkg::store_st) &&
                       (cur.timer == 10'd1);

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    next_st       = cur;
    next_st.rdata = nvm_self_access_pkg::reset_zero;

    // ************************************************************
    // register reads
    // ************************************************************
    if (req.rd) begin
      unique case (req.sel)
        nvm_self_access_pkg::sel_control: begin
          next_st.rdata = {cur.space_select, 3'h0, cur.aborted, cur.store_permit,
                           cur.store_go, cur.fetch_go};
        end
        nvm_self_access_pkg::sel_data_low: begin
          next_st.rdata = cur.data_low;
        end
        nvm_self_access_pkg::sel_data_high: begin
          next_st.rdata = cur.data_high;
        end
        nvm_self_access_pkg::sel_addr_low: begin
          next_st.rdata = cur.addr_low;
        end
        nvm_self_access_pkg::sel_addr_high: begin
          next_st.rdata = cur.addr_high;
        end
        nvm_self_access_pkg::sel_flags_two: begin
          next_st.rdata = {3'h0, cur.store_done, 4'h0};
        end
        default: begin
          // the unlock register has no storage behind it
          next_st.rdata = nvm_self_access_pkg::reset_zero;
        end
      endcase
    end

    // ************************************************************
    // register writes; the core is held off while a read stalls it
    // ************************************************************
    if (req.wr && !cur.stall) begin
      unique case (req.sel)
        nvm_self_access_pkg::sel_control: begin
          // space only moves between operations, so a busy write keeps its target
          if (cur.phase == nvm_self_access_pkg::idle_st) begin
            next_st.space_select = wr_space;
          end
          next_st.store_permit = wr_permit;
          next_st.aborted      = req.wdata[nvm_self_access_pkg::bit_aborted];
          // a zero in a go bit is ignored, so software cannot cut a write short
          if (req.wdata[nvm_self_access_pkg::bit_fetch_go] &&
              cur.phase == nvm_self_access_pkg::idle_st) begin
            next_st.fetch_go = 1'b1;
            if (wr_space) begin
              next_st.phase = nvm_self_access_pkg::fetch_st;
              next_st.timer = 10'(nvm_self_access_pkg::fetch_cycles);
              next_st.stall = 1'b1;
            end else begin
              next_st.data_low = data_mem[data_index];
              next_st.fetch_go = 1'b0;
            end
          end
          if (req.wdata[nvm_self_access_pkg::bit_store_go] &&
              cur.phase == nvm_self_access_pkg::idle_st &&
              cur.unlock_step == 2'd2 && wr_permit && prot_ok) begin
            next_st.store_go = 1'b1;
            next_st.phase    = nvm_self_access_pkg::store_st;
            next_st.timer    = 10'(nvm_self_access_pkg::store_cycles);
            next_st.pump_on  = wr_space || !data_unimpl;
          end
          // any control write ends the unlock pattern, used or not
          next_st.unlock_step = 2'd0;
        end
        nvm_self_access_pkg::sel_unlock: begin
          if (req.wdata == nvm_self_access_pkg::unlock_first) begin
            next_st.unlock_step = 2'd1;
          end else if (req.wdata == nvm_self_access_pkg::unlock_second &&
                       cur.unlock_step == 2'd1) begin
            next_st.unlock_step = 2'd2;
          end else begin
            next_st.unlock_step = 2'd0;
          end
        end
        nvm_self_access_pkg::sel_data_low: begin
          next_st.data_low = req.wdata;
        end
        nvm_self_access_pkg::sel_data_high: begin
          next_st.data_high = {2'b00, req.wdata[5:0]};
        end
        nvm_self_access_pkg::sel_addr_low: begin
          next_st.addr_low = req.wdata;
        end
        nvm_self_access_pkg::sel_addr_high: begin
          next_st.addr_high = {3'b000, req.wdata[4:0]};
        end
        nvm_self_access_pkg::sel_flags_two: begin
          next_st.store_done = req.wdata[nvm_self_access_pkg::bit_store_done];
        end
        default: begin
          next_st.unlock_step = cur.unlock_step;
        end
      endcase
    end

    // ************************************************************
    // timed operations; completion comes after the writes so a set wins
    // ************************************************************
    unique case (cur.phase)
      nvm_self_access_pkg::idle_st: begin
      end
      nvm_self_access_pkg::fetch_st: begin
        next_st.timer = cur.timer - 10'd1;
        if (cur.timer == 10'd1) begin
          next_st.data_low  = prog_mem[prog_index][7:0];
          next_st.data_high = {2'b00, prog_mem[prog_index][13:8]};
          next_st.fetch_go  = 1'b0;
          next_st.stall     = 1'b0;
          next_st.phase     = nvm_self_access_pkg::idle_st;
        end
      end
      nvm_self_access_pkg::store_st: begin
        next_st.timer = cur.timer - 10'd1;
        if (store_end) begin
          next_st.store_go   = 1'b0;
          next_st.store_done = 1'b1;
          next_st.pump_on    = 1'b0;
          next_st.phase      = nvm_self_access_pkg::idle_st;
        end
      end
    endcase
  end

  // ************************************************************
  // memory array update: erase then program in one step
  // ************************************************************
  // the four-word block takes the same word in each slot; a real latch set is out of scope
  always_ff @(posedge sys_clk) begin
    if (store_end && !cur.space_select && !data_unimpl)
      data_mem[data_index] <= cur.data_low;
    if (store_end && cur.space_select) begin
      for (int i = 0; i < 4; i++)
        prog_mem[{prog_index[11:2], 2'(i)}] <= {cur.data_high[5:0], cur.data_low};
    end
  end

  // ************************************************************
  // state register; warm reset keeps address and data
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else if (por) begin
      cur <= '0;
    end else if (warm_reset) begin
      cur.aborted      <= cur.aborted | (cur.phase == nvm_self_access_pkg::store_st);
      cur.phase        <= nvm_self_access_pkg::idle_st;
      cur.fetch_go     <= 1'b0;
      cur.store_go     <= 1'b0;
      cur.space_select <= 1'b0;
      cur.store_permit <= 1'b0;
      cur.stall        <= 1'b0;
      cur.pump_on      <= 1'b0;
      cur.unlock_step  <= 2'd0;
      cur.rdata        <= 8'h00;
    end else begin
      cur <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rdata   = cur.rdata;
  assign stall   = cur.stall;
  assign pump_on = cur.pump_on;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) prog_access_ok <= 1'b0;
    else     prog_access_ok <= prog_req && !code_protect;
  end

endmodule : nvm_self_access

/* nvm_self_access_props.sv */
// checker for the nvm self-access controller ports
// assumes one clock, rst asynchronous and por synchronous
`timescale 1ns/1ps
module nvm_self_access_props (
  input wire logic                             sys_clk,
  input wire logic                             rst,
  input wire logic                             por,
  input wire logic                             warm_reset,
  input wire nvm_self_access_pkg::reg_req_type req,
  input wire logic                             block_protect,
  input wire logic                             code_protect,
  input wire logic                             prog_req,
  input wire logic [7:0]                       rdata,
  input wire logic                             stall,
  input wire logic                             pump_on,
  input wire logic                             prog_access_ok
);
  // ****
  // timing relations
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || por);
  logic [10:0] high_run;
  wire         ctl_wr = req.wr && !stall && req.sel == nvm_self_access_pkg::sel_control;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      high_run <= 11'h000;
    end else begin
      high_run <= pump_on ? high_run + 11'h001 : 11'h000;
    end
  end
  sequence s_fetch_start;
    ctl_wr && !pump_on && req.wdata[0] && req.wdata[7];
  endsequence
  sequence s_stall_run;
    stall [*2] ##1 !stall;
  endsequence
  a_unlock_zero: assert property (
    req.rd && req.sel == nvm_self_access_pkg::sel_unlock |=> rdata == 8'h00)
    else $error("unlock read not zero");
  a_access_gate: assert property (
    1'b1 |=> prog_access_ok == $past(prog_req && !code_protect))
    else $error("programmer access gate wrong");
  a_fetch_stall: assert property (s_fetch_start |=> s_stall_run)
    else $error("program read stall not two cycles");
  a_stall_cause: assert property ($rose(stall) |-> $past(ctl_wr && req.wdata[0]))
    else $error("stall without read start");
  a_pump_cause: assert property (
    $rose(pump_on) |-> $past(ctl_wr && req.wdata[1] && req.wdata[2])
    && $past(req.wr && req.wdata == nvm_self_access_pkg::unlock_second, 2))
    else $error("pump on without unlock and permit");
  a_pump_time: assert property (
    $fell(pump_on) && !$past(warm_reset) && !$past(por) |->
    high_run >= 11'h3e7 && high_run <= 11'h3e8) else $error("write length wrong");
  a_protect_blocks: assert property (
    ctl_wr && req.wdata[1] && req.wdata[7] && block_protect |=> !pump_on)
    else $error("protected program write started");
  a_warm_stop: assert property (warm_reset |=> !pump_on && !stall)
    else $error("warm reset left operation running");
endmodule : nvm_self_access_props
bind nvm_self_access nvm_self_access_props props (
  .sys_clk(sys_clk), .rst(rst), .por(por), .warm_reset(warm_reset), .req(req),
  .block_protect(block_protect), .code_protect(code_protect), .prog_req(prog_req),
  .rdata(rdata), .stall(stall), .pump_on(pump_on), .prog_access_ok(prog_access_ok)
);

/* nvm_core_model.sv */
// core-side register master for the nvm controller
// assumes writes are taken on a rising edge with stall low
`timescale 1ns/1ps
module nvm_core_model (
  input  wire logic                       sys_clk,
  input  wire logic                       stall,
  input  wire logic [7:0]                 rdata,
  output nvm_self_access_pkg::reg_req_type req
);
  // ****
  // bus cycles, changed on the falling edge
  // ****
  initial req = '0;
  // a write stays up until taken, so a stall only slows the core
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    @(posedge sys_clk);
    while (stall !== 1'b0) @(posedge sys_clk);
  endtask : wr
  task automatic idle;
    @(negedge sys_clk);
    req <= '0;
  endtask : idle
  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    @(negedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
    @(negedge sys_clk);
    req <= '0;
    d = rdata;
  endtask : rd
  task automatic point(input logic [15:0] a);
    wr(nvm_self_access_pkg::sel_addr_high, a[15:8]);
    wr(nvm_self_access_pkg::sel_addr_low, a[7:0]);
  endtask : point
  task automatic store(input logic [7:0] ctl);
    wr(nvm_self_access_pkg::sel_unlock, nvm_self_access_pkg::unlock_first);
    wr(nvm_self_access_pkg::sel_unlock, nvm_self_access_pkg::unlock_second);
    wr(nvm_self_access_pkg::sel_control, ctl);
    idle();
  endtask : store
  task automatic fetch(input logic [7:0] sp, output logic [7:0] n);
    wr(nvm_self_access_pkg::sel_control, sp);
    wr(nvm_self_access_pkg::sel_control, sp | 8'h01);
    idle();
    n = 8'h00;
    while (stall === 1'b1 && n < 8'h10) begin
      n = n + 8'h01;
      @(negedge sys_clk);
    end
  endtask : fetch
endmodule : nvm_core_model

/* nvm_self_access_tb.sv */
// self-checking bench for the nvm self-access controller
// assumes the core model issues every register access
`timescale 1ns/1ps
module nvm_self_access_tb;
  // ****
  // stimulus, reference memories and checks
  // ****
  nvm_self_access_pkg::reg_req_type req;
  logic                             sys_clk, rst, por, warm_reset, e;
  logic                             block_protect, code_protect, prog_req;
  logic                             stall, pump_on, prog_access_ok;
  logic [7:0]                       rdata, v, n;
  logic [15:0]                      a;
  logic [13:0]                      w;
  logic [7:0]                       dmem [128];
  logic [13:0]                      pmem [4096];
  int                               failures = 0, tests_run = 0, cycles = 0;
  int                               seed = 32'h69ed;
  nvm_self_access uut (.sys_clk(sys_clk), .rst(rst), .por(por), .warm_reset(warm_reset),
    .req(req), .block_protect(block_protect), .code_protect(code_protect),
    .prog_req(prog_req), .rdata(rdata), .stall(stall), .pump_on(pump_on),
    .prog_access_ok(prog_access_ok));
  nvm_core_model core (.sys_clk(sys_clk), .stall(stall), .rdata(rdata), .req(req));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // a write runs its full timed length before the flags are looked at
  task automatic settle(input logic ok);
    repeat (nvm_self_access_pkg::store_cycles + 4) @(negedge sys_clk);
    core.rd(nvm_self_access_pkg::sel_flags_two, v);
    if (ok) chk("store_done", 8'h01, {7'h00, v[4]});
    core.wr(nvm_self_access_pkg::sel_flags_two, 8'h00);
    core.rd(nvm_self_access_pkg::sel_control, v);
    chk("store_go", 8'h00, {7'h00, v[1]});
  endtask : settle
  task automatic dstore(input logic [7:0] ad, input logic [7:0] d);
    core.wr(nvm_self_access_pkg::sel_addr_low, ad);
    core.wr(nvm_self_access_pkg::sel_data_low, d);
    core.store(8'h06);
    chk("pump_on", {7'h00, ~ad[7]}, {7'h00, pump_on});
    if (!ad[7]) dmem[ad[6:0]] = d;
    settle(!ad[7]);
  endtask : dstore
  task automatic dcheck(input logic [7:0] ad);
    core.wr(nvm_self_access_pkg::sel_addr_low, ad);
    core.fetch(8'h00, n);
    core.rd(nvm_self_access_pkg::sel_data_low, v);
    chk("data_low", dmem[ad[6:0]], v);
  endtask : dcheck
  task automatic pstore(input logic [15:0] ad, input logic [13:0] d);
    core.point(ad);
    core.wr(nvm_self_access_pkg::sel_data_low, d[7:0]);
    core.wr(nvm_self_access_pkg::sel_data_high, {2'b00, d[13:8]});
    core.store(8'h86);
    chk("pump_on", {7'h00, ~block_protect}, {7'h00, pump_on});
    for (int k = 0; k < 4; k++) if (!block_protect) pmem[{ad[11:2], 2'(k)}] = d;
    settle(!block_protect);
  endtask : pstore
  task automatic pcheck(input logic [15:0] ad);
    core.point(ad);
    core.fetch(8'h80, n);
    chk("stall_cycles", 8'h02, n);
    core.rd(nvm_self_access_pkg::sel_data_high, v);
    chk("data_high", {2'b00, pmem[ad[11:0]][13:8]}, v & 8'h3f);
    core.rd(nvm_self_access_pkg::sel_data_low, v);
    chk("data_low", pmem[ad[11:0]][7:0], v);
  endtask : pcheck
  initial begin
    {rst, por, warm_reset, block_protect, code_protect, prog_req} = 6'h30;
    repeat (12) @(negedge sys_clk);
    {rst, por} = 2'b00;
    core.rd(nvm_self_access_pkg::sel_control, v);
    chk("control", 8'h00, v);
    core.wr(nvm_self_access_pkg::sel_unlock, 8'haa);
    core.rd(nvm_self_access_pkg::sel_unlock, v);
    chk("unlock", 8'h00, v);
    code_protect = 1'b1;
    for (int i = 0; i < 3; i++) begin
      a = 16'($random(seed));
      w = 14'($random(seed));
      dstore({1'b0, a[6:0]}, w[7:0]);
      dcheck({1'b1, a[6:0]});
      dstore({1'b1, a[6:0]}, ~w[7:0]);
      dcheck({1'b0, a[6:0]});
      a = 16'($random(seed)) & 16'h1fff;
      pstore(a, w);
      pcheck(a ^ 16'h1001);
    end
    block_protect = 1'b1;
    pstore(a, ~w);
    block_protect = 1'b0;
    pcheck(a);
    core.wr(nvm_self_access_pkg::sel_control, 8'h06);
    core.idle();
    chk("pump_on", 8'h00, {7'h00, pump_on});
    core.store(8'h02);
    chk("pump_on", 8'h00, {7'h00, pump_on});
    core.wr(nvm_self_access_pkg::sel_addr_low, 8'h15);
    core.store(8'h06);
    core.wr(nvm_self_access_pkg::sel_control, 8'h04);
    core.rd(nvm_self_access_pkg::sel_control, v);
    chk("store_go", 8'h01, {7'h00, v[1]});
    warm_reset = 1'b1;
    @(negedge sys_clk);
    warm_reset = 1'b0;
    core.rd(nvm_self_access_pkg::sel_control, v);
    chk("aborted", 8'h01, {7'h00, v[3]});
    core.rd(nvm_self_access_pkg::sel_addr_low, v);
    chk("addr_low", 8'h15, v);
    for (int i = 0; i < 16; i++) begin
      prog_req = 1'($random(seed));
      code_protect = 1'($random(seed));
      e = prog_req & ~code_protect;
      @(negedge sys_clk);
      chk("prog_access_ok", {7'h00, e}, {7'h00, prog_access_ok});
    end
    stop_test();
  end
endmodule : nvm_self_access_tb
